// ### rtl/xlate_consts.vh
// constants of the store address translator: register map, fields, encodings
`ifndef XLATE_CONSTS_VH
`define XLATE_CONSTS_VH
// register byte offsets on the AXI4-Lite bus
`define OFF_SAR 8'h00
`define OFF_SCR 8'h04
`define OFF_PSW 8'h08
`define OFF_REFILL 8'h0C
`define OFF_CTRL 8'h10
`define OFF_STATUS 8'h14
`define OFF_RESULT 8'h18
// reset values
`define SAR_RST 24'h000000
`define SCR_RST 32'h00000000
`define PSW_RST 32'h00000000
// virtual address fields
`define VA_SEG_HI 23
`define VA_SEG_LO 17
`define VA_PAGE_HI 16
`define VA_PAGE_LO 11
`define VA_OFF_HI 10
// control bits
`define PSW_XLATE_BIT 7
`define SCR_XLATE_BIT 20
`define SCR_WRITE_BIT 16
`define SCR_WAYB_BIT 21
`define CTRL_INVAL_BIT 0
// entry fields
`define ENT_RELOC_HI 23
`define ENT_RELOC_LO 11
`define ENT_NOWRITE_BIT 10
`define ENT_NOREAD_BIT 9
`define ENT_VALID_BIT 7
`define ENT_TAG_HI 6
// status bits
`define ST_HIT_BIT 0
`define ST_MISS_BIT 1
`define ST_PROT_BIT 2
`define ST_FAULT_BIT 3
`define ST_BUSY_BIT 4
// bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ### rtl/xlate_lookup_copy.v
// one copy of buffer index generation and per-way hit detection
`timescale 1ns/10ps
`include "xlate_consts.vh"
module xlate_lookup_copy (
    input wire [23:0] va,
    input wire [2:0] block_sel,
    input wire translate_en,
    input wire [23:0] entry_a,
    input wire [23:0] entry_b,
    output wire [9:0] index,
    output wire hit_a,
    output wire hit_b
);
    wire [6:0] lookup_tag;
    wire [5:0] entry_sel;

    // tag from va 23..20 and 16..14, entry select from va 19..17 and 13..11
    assign lookup_tag = {va[23:20], va[16:14]};
    assign entry_sel = {va[19:17], va[13:11]};
    // index bit 6 is never driven high: only 512 of 1024 slots exist
    assign index = {block_sel, 1'b0, entry_sel};
    // a way hits only on a valid entry whose tag matches
    assign hit_a = translate_en && entry_a[`ENT_VALID_BIT]
        && (entry_a[`ENT_TAG_HI:0] == lookup_tag);
    assign hit_b = translate_en && entry_b[`ENT_VALID_BIT]
        && (entry_b[`ENT_TAG_HI:0] == lookup_tag);
endmodule

// ### rtl/store_address_translator.v
// two-way store address translator with an AXI4-Lite register port
// Overview of operation
// - virtual address splits into 7-bit segment, 6-bit page, 11-bit offset.
// - 2K pages; offset passes untouched, unused by translation or protection.
// - upper 13 bits look up the buffer; 13-bit page returned, offset forwarded.
// - no valid matching entry raises a miss toward controller and cache.
// - forbidden access on a hit is blocked, error bit set, violation raised.
// - status bit 7 or control bit 20 zero disables translation and protection.
// - index built from address and status word bits 2..0; bit 6 unused, 512 entries.
// - index is block select of eight and entry select of sixty-four.
// - two ways of 512 entries, 24 bits, one parity bit per byte.
// - relocation fields of both ways go to the cache together.
// - bypass disables way A and routes address bits 23..11 straight through.
// - main store bus carries relocation of the hitting way plus access kind.
// - entry bit 7 is the valid flag when not bypassed.
// - hit needs valid and tag 23..20,16..14 equal to entry 6..0.
// - relocation comes from entry bits 23..11 of the hitting way.
// - hit, protection and relocation are evaluated and qualified together.
// - good hit goes to cache; on cache miss, to main store bus.
// - index and hit logic exist twice and are cross-checked.
// - both ways hitting in one access is a hardware fault.
// - protection checks suppressed when bypassed or missing.
// - refill with both ways invalid writes way A.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "xlate_consts.vh"
module store_address_translator #(
    parameter ENTRIES = 512,
    parameter AW = 8
) (
    input wire sys_clk,
    input wire rst,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cache_miss,
    output reg [12:0] cache_page_a,
    output reg [12:0] cache_page_b,
    output reg [10:0] cache_offset,
    output reg cache_hit_a,
    output reg cache_hit_b,
    output reg cache_addr_valid,
    output reg xlate_miss,
    output reg prot_violation,
    output reg hw_fault,
    output reg [12:0] main_memory_address_bus,
    output reg main_memory_write,
    output reg main_memory_addr_valid
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LOOK = 3'b010;
    localparam [2:0] ST_INVAL = 3'b100;

    reg [2:0] state_r;
    reg [8:0] inval_cnt_r;
    reg [23:0] store_address_reg;
    reg [31:0] store_control_reg;
    reg [31:0] program_status_word;
    reg [23:0] result_r;
    reg st_hit_r, st_miss_r, st_prot_r, st_fault_r;
    reg [AW-1:0] wr_addr_r;
    reg [26:0] way_a_mem [0:ENTRIES-1];
    reg [26:0] way_b_mem [0:ENTRIES-1];

    wire translate_en;
    wire [9:0] idx_x, idx_y;
    wire hit_a_x, hit_b_x, hit_a_y, hit_b_y;
    wire [8:0] mem_addr;
    wire [26:0] rd_a, rd_b;
    wire [23:0] ent_a, ent_b, sel_ent;
    wire any_hit, multi_hit, copy_mismatch, parity_err, fault_now;
    wire is_write, prot_bad, access_ok;
    wire [12:0] phys_page;
    wire wr_fire, rd_fire;
    wire [3:0] st_clear;
    reg [31:0] rd_mux;
    reg [26:0] refill_word;
    reg refill_to_b;

    // odd parity for one byte
    function par;
        input [7:0] b;
        begin
            par = ~^b;
        end
    endfunction

    // zero in either control bit turns translation off
    assign translate_en = program_status_word[`PSW_XLATE_BIT]
        & store_control_reg[`SCR_XLATE_BIT];
    assign mem_addr = {idx_x[9:7], idx_x[5:0]};
    assign rd_a = way_a_mem[mem_addr];
    assign rd_b = way_b_mem[mem_addr];
    // bypass disables way A toward the hit logic
    assign ent_a = translate_en ? rd_a[23:0] : 24'h000000;
    assign ent_b = rd_b[23:0];

    // two identical copies of index and hit logic for self-checking
    xlate_lookup_copy copy_x (
        .va(store_address_reg),
        .block_sel(program_status_word[2:0]),
        .translate_en(translate_en),
        .entry_a(ent_a),
        .entry_b(ent_b),
        .index(idx_x),
        .hit_a(hit_a_x),
        .hit_b(hit_b_x)
    );
    xlate_lookup_copy copy_y (
        .va(store_address_reg),
        .block_sel(program_status_word[2:0]),
        .translate_en(translate_en),
        .entry_a(ent_a),
        .entry_b(ent_b),
        .index(idx_y),
        .hit_a(hit_a_y),
        .hit_b(hit_b_y)
    );

    // hit qualification, protection and fault detection in one pass
    assign copy_mismatch = (idx_x != idx_y) || (hit_a_x != hit_a_y)
        || (hit_b_x != hit_b_y);
    assign any_hit = hit_a_x | hit_b_x;
    assign multi_hit = hit_a_x & hit_b_x;
    // parity only matters while the entries are actually used
    assign parity_err = translate_en && (
        (rd_a[24] != par(rd_a[7:0])) || (rd_a[25] != par(rd_a[15:8]))
        || (rd_a[26] != par(rd_a[23:16])) || (rd_b[24] != par(rd_b[7:0]))
        || (rd_b[25] != par(rd_b[15:8])) || (rd_b[26] != par(rd_b[23:16])));
    assign fault_now = multi_hit | copy_mismatch | parity_err;
    assign sel_ent = hit_a_x ? ent_a : ent_b;
    assign is_write = store_control_reg[`SCR_WRITE_BIT];
    // protection looked at only on a hit with translation on
    assign prot_bad = translate_en && any_hit && (is_write ?
        sel_ent[`ENT_NOWRITE_BIT] : sel_ent[`ENT_NOREAD_BIT]);
    assign access_ok = !translate_en || (any_hit && !prot_bad && !fault_now);
    // bypassed: va 23..11 is the physical page
    assign phys_page = translate_en ? sel_ent[`ENT_RELOC_HI:`ENT_RELOC_LO]
        : store_address_reg[`VA_SEG_HI:`VA_PAGE_LO];

    assign wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign st_clear = (wr_fire && s_axi_awaddr == `OFF_STATUS) ? s_axi_wdata[3:0] : 4'h0;

    // refill data with parity and way choice from the indexed valid bits
    always @* begin
        refill_word = {par(s_axi_wdata[23:16]), par(s_axi_wdata[15:8]),
            par(s_axi_wdata[7:0]), s_axi_wdata[23:0]};
        if (!rd_a[`ENT_VALID_BIT]) begin
            refill_to_b = 1'b0;
        end else if (!rd_b[`ENT_VALID_BIT]) begin
            refill_to_b = 1'b1;
        end else begin
            refill_to_b = store_control_reg[`SCR_WAYB_BIT];
        end
    end

    // buffer storage; invalidation sweeps zero entries with good parity
    always @(posedge sys_clk) begin
        if (state_r == ST_INVAL) begin
            way_a_mem[inval_cnt_r] <= 27'h7000000;
            way_b_mem[inval_cnt_r] <= 27'h7000000;
        end else if (wr_fire && s_axi_awaddr == `OFF_REFILL && state_r == ST_IDLE) begin
            if (refill_to_b) begin
                way_b_mem[mem_addr] <= refill_word;
            end else begin
                way_a_mem[mem_addr] <= refill_word;
            end
        end
    end

    // write channels taken together, one cycle ready pulse, no write while busy
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid
                && !s_axi_bvalid && state_r == ST_IDLE;
            s_axi_wready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid
                && !s_axi_bvalid && state_r == ST_IDLE;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr <= `OFF_STATUS
                    && s_axi_awaddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read data mux; result register is read only
    always @* begin
        case (s_axi_araddr)
            `OFF_SAR: rd_mux = {8'h00, store_address_reg};
            `OFF_SCR: rd_mux = store_control_reg;
            `OFF_PSW: rd_mux = program_status_word;
            `OFF_STATUS: rd_mux = {27'h0, state_r != ST_IDLE, st_fault_r, st_prot_r,
                st_miss_r, st_hit_r};
            `OFF_RESULT: rd_mux = {8'h00, result_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read channel, one access at a time
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (s_axi_araddr == `OFF_SAR || s_axi_araddr == `OFF_SCR
                    || s_axi_araddr == `OFF_PSW || s_axi_araddr == `OFF_STATUS
                    || s_axi_araddr == `OFF_RESULT) ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // loaded registers; byte strobes honoured on the store control word only
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            store_address_reg <= `SAR_RST;
            store_control_reg <= `SCR_RST;
            program_status_word <= `PSW_RST;
        end else if (wr_fire) begin
            if (s_axi_awaddr == `OFF_SAR) begin
                store_address_reg <= s_axi_wdata[23:0];
            end
            if (s_axi_awaddr == `OFF_SCR) begin
                store_control_reg <= {s_axi_wstrb[3] ? s_axi_wdata[31:24] : store_control_reg[31:24],
                    s_axi_wstrb[2] ? s_axi_wdata[23:16] : store_control_reg[23:16],
                    s_axi_wstrb[1] ? s_axi_wdata[15:8] : store_control_reg[15:8],
                    s_axi_wstrb[0] ? s_axi_wdata[7:0] : store_control_reg[7:0]};
            end
            if (s_axi_awaddr == `OFF_PSW) begin
                program_status_word <= s_axi_wdata;
            end
        end
    end

    // sequencer: a write of the address starts a lookup the next cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            inval_cnt_r <= 9'h000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    inval_cnt_r <= 9'h000;
                    if (wr_fire && s_axi_awaddr == `OFF_SAR) begin
                        state_r <= ST_LOOK;
                    end else if (wr_fire && s_axi_awaddr == `OFF_CTRL
                        && s_axi_wdata[`CTRL_INVAL_BIT]) begin
                        state_r <= ST_INVAL;
                    end
                end
                ST_LOOK: state_r <= ST_IDLE;
                ST_INVAL: begin
                    inval_cnt_r <= inval_cnt_r + 9'h001;
                    if (inval_cnt_r == 9'h1FF) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // lookup results toward cache and controller, qualified in the same cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cache_page_a <= 13'h0000;
            cache_page_b <= 13'h0000;
            cache_offset <= 11'h000;
            cache_hit_a <= 1'b0;
            cache_hit_b <= 1'b0;
            cache_addr_valid <= 1'b0;
            xlate_miss <= 1'b0;
            prot_violation <= 1'b0;
            hw_fault <= 1'b0;
            result_r <= 24'h000000;
        end else if (state_r == ST_LOOK) begin
            // both ways sent at once so the cache can overlap its own compare
            cache_page_a <= translate_en ? ent_a[`ENT_RELOC_HI:`ENT_RELOC_LO]
                : store_address_reg[`VA_SEG_HI:`VA_PAGE_LO];
            cache_page_b <= ent_b[`ENT_RELOC_HI:`ENT_RELOC_LO];
            cache_offset <= store_address_reg[`VA_OFF_HI:0];
            cache_hit_a <= hit_a_x | !translate_en;
            cache_hit_b <= hit_b_x;
            cache_addr_valid <= access_ok;
            xlate_miss <= translate_en && !any_hit;
            prot_violation <= prot_bad;
            hw_fault <= fault_now;
            if (access_ok) begin
                result_r <= {phys_page, store_address_reg[`VA_OFF_HI:0]};
            end
        end else if (state_r == ST_INVAL) begin
            cache_addr_valid <= 1'b0;
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_hit_r <= 1'b0;
            st_miss_r <= 1'b0;
            st_prot_r <= 1'b0;
            st_fault_r <= 1'b0;
        end else begin
            st_hit_r <= (state_r == ST_LOOK && any_hit) | (st_hit_r & !st_clear[0]);
            st_miss_r <= (state_r == ST_LOOK && translate_en && !any_hit)
                | (st_miss_r & !st_clear[1]);
            st_prot_r <= (state_r == ST_LOOK && prot_bad) | (st_prot_r & !st_clear[2]);
            st_fault_r <= (state_r == ST_LOOK && fault_now) | (st_fault_r & !st_clear[3]);
        end
    end

    // cache miss on a good address forwards it to main store
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            main_memory_address_bus <= 13'h0000;
            main_memory_write <= 1'b0;
            main_memory_addr_valid <= 1'b0;
        end else if (state_r == ST_LOOK) begin
            main_memory_addr_valid <= 1'b0;
        end else if (cache_miss && cache_addr_valid) begin
            main_memory_address_bus <= result_r[23:11];
            main_memory_write <= is_write;
            main_memory_addr_valid <= 1'b1;
        end
    end
endmodule

// ### tb/store_address_translator_asserts.sv
// port checker for the store address translator
`timescale 1ns/10ps
module store_address_translator_asserts (
    input wire sys_clk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire cache_miss,
    input wire [12:0] cache_page_a,
    input wire [12:0] cache_page_b,
    input wire cache_hit_a,
    input wire cache_hit_b,
    input wire cache_addr_valid,
    input wire xlate_miss,
    input wire prot_violation,
    input wire hw_fault,
    input wire [12:0] main_memory_address_bus,
    input wire main_memory_addr_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // lookup outcome flags must agree with each other
    AST_HIT_FAULT: assert property (cache_hit_a && cache_hit_b |-> hw_fault && !cache_addr_valid)
        else $error("double hit without fault");
    AST_MISS_NO_HIT: assert property (xlate_miss |-> !cache_hit_a && !cache_hit_b)
        else $error("miss with a way hit");
    AST_MISS_NO_PROT: assert property (xlate_miss |-> !prot_violation)
        else $error("protection checked on a miss");
    AST_PROT_BLOCKS: assert property (prot_violation |-> !cache_addr_valid)
        else $error("violating access let through");
    AST_VALID_CAUSE: assert property (cache_addr_valid |-> !xlate_miss && !hw_fault)
        else $error("address qualified despite miss or fault");
    // idle bus so no lookup can overtake the forwarded address
    AST_MM_FOLLOWS: assert property (cache_miss && cache_addr_valid && !s_axi_awvalid && !s_axi_bvalid
        |=> main_memory_addr_valid && main_memory_address_bus ==
        (cache_hit_b ? cache_page_b : cache_page_a))
        else $error("main store address not forwarded");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_B_AFTER_AW: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("no write response after address");
    cover property (cache_hit_b && cache_addr_valid);
    cover property (prot_violation);
    cover property (main_memory_addr_valid && !hw_fault);
endmodule

bind store_address_translator store_address_translator_asserts u_asserts (.sys_clk, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .cache_miss, .cache_page_a, .cache_page_b, .cache_hit_a,
    .cache_hit_b, .cache_addr_valid, .xlate_miss, .prot_violation, .hw_fault,
    .main_memory_address_bus, .main_memory_addr_valid);

// ### tb/cache_model.sv
// cache side model that reports a cache miss on request
`timescale 1ns/10ps
module cache_model (
    input wire sys_clk,
    input wire rst,
    input wire cache_addr_valid,
    input wire miss_req,
    input wire [3:0] lag,
    output reg cache_miss
);
    reg armed_r;
    reg [3:0] wait_r;
    // only a qualified address can miss; lag gives prompt or slow answers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
            wait_r <= 4'h0;
            cache_miss <= 1'b0;
        end else begin
            cache_miss <= 1'b0;
            if (miss_req && cache_addr_valid) begin
                armed_r <= 1'b1;
                wait_r <= lag;
            end else if (armed_r && wait_r == 4'h0) begin
                armed_r <= 1'b0;
                cache_miss <= 1'b1;
            end else if (armed_r) begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end
endmodule

// ### tb/testbench.sv
// register-level testbench for the store address translator
`timescale 1ns/10ps
`include "xlate_consts.vh"
module testbench;
    localparam [23:0] VA1 = {4'hA, 3'h2, 3'h5, 3'h3, 11'h17B};
    localparam [23:0] VA2 = {4'h3, 3'h2, 3'h6, 3'h3, 11'h055};
    localparam [23:0] VA3 = {4'h7, 3'h1, 3'h1, 3'h4, 11'h000};
    localparam [31:0] XON = 32'h00100000;
    reg sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg miss_req;
    reg [7:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata, rd_data;
    reg [3:0] s_axi_wstrb, lag;
    reg [1:0] rd_resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cache_miss;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [12:0] cache_page_a, cache_page_b, main_memory_address_bus;
    wire [10:0] cache_offset;
    wire cache_hit_a, cache_hit_b, cache_addr_valid, xlate_miss, prot_violation, hw_fault;
    wire main_memory_write, main_memory_addr_valid;
    integer n_errors, comparisons, k;

    store_address_translator u_store_address_translator (.sys_clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cache_miss, .cache_page_a,
        .cache_page_b, .cache_offset, .cache_hit_a, .cache_hit_b, .cache_addr_valid, .xlate_miss,
        .prot_violation, .hw_fault, .main_memory_address_bus, .main_memory_write,
        .main_memory_addr_valid);
    cache_model u_cache_model (.sys_clk, .rst, .cache_addr_valid, .miss_req, .lag, .cache_miss);

    // free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task close_out;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask

    task timed_out;
        begin
            n_errors = n_errors + 1;
            $display("Error at %0t: wait ran out", $time);
            close_out;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // outcome flags: hit a, hit b, qualified, miss, violation, fault
    task outs(input [5:0] exp);
        chk({cache_hit_a, cache_hit_b, cache_addr_valid, xlate_miss, prot_violation, hw_fault}, exp);
    endtask

    // write: address and data offered together, each dropped once taken
    task wr(input [7:0] a, input [31:0] d, input [1:0] exp);
        integer j;
        reg done;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hF;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            done = 1'b0;
            for (j = 0; j < 2000 && !done; j = j + 1) begin
                @(posedge sys_clk);
                if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid === 1'h1) begin
                    done = 1'b1;
                    chk(s_axi_bresp, exp);
                end
            end
            if (!done) timed_out;
            s_axi_bready <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task rd(input [7:0] a);
        integer j;
        reg done;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            done = 1'b0;
            for (j = 0; j < 2000 && !done; j = j + 1) begin
                @(posedge sys_clk);
                if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid === 1'h1) begin
                    done = 1'b1;
                    rd_data = s_axi_rdata;
                    rd_resp = s_axi_rresp;
                end
            end
            if (!done) timed_out;
            s_axi_rready <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    // ask the cache to miss, then wait for the main store address
    task miss_run(input [3:0] l);
        integer j;
        begin
            lag <= l;
            miss_req <= 1'b1;
            @(posedge sys_clk);
            miss_req <= 1'b0;
            for (j = 0; j < 50 && main_memory_addr_valid !== 1'h1; j = j + 1) @(posedge sys_clk);
            if (main_memory_addr_valid !== 1'h1) timed_out;
        end
    endtask

    function [23:0] ent(input [12:0] rl, input nw, input [6:0] tg);
        ent = {rl, nw, 2'h0, 1'h1, tg};
    endfunction

    // main sequence
    initial begin
        n_errors = 0;
        comparisons = 0;
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, lag, miss_req} = 57'h0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // buffer memory is not reset: clear it first
        wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
        rd_data = 32'h10;
        for (k = 0; k < 400 && rd_data[4] !== 1'h0; k = k + 1) rd(`OFF_STATUS);
        if (rd_data[4] !== 1'h0) timed_out;
        // translation off by either control bit
        for (k = 0; k < 2; k = k + 1) begin
            wr(`OFF_PSW, (k == 1) ? 32'h85 : 32'h0, `RESP_OKAY);
            wr(`OFF_SCR, (k == 1) ? 32'h0 : XON, `RESP_OKAY);
            wr(`OFF_SAR, {8'h0, VA1}, `RESP_OKAY);
            chk(cache_page_a, VA1[23:11]);
            chk(cache_offset, VA1[10:0]);
            outs(6'h28);
            rd(`OFF_RESULT);
            chk(rd_data, {8'h0, VA1});
        end
        wr(`OFF_PSW, 32'h85, `RESP_OKAY);
        wr(`OFF_SCR, XON, `RESP_OKAY);
        wr(`OFF_SAR, {8'h0, VA1}, `RESP_OKAY);
        outs(6'h04);
        wr(`OFF_REFILL, {8'h0, ent(13'h1ABC, 1'h1, {4'hA, 3'h5})}, `RESP_OKAY);
        wr(`OFF_SAR, {8'h0, VA1}, `RESP_OKAY);
        outs(6'h28);
        chk(cache_page_a, 13'h1ABC);
        rd(`OFF_RESULT);
        chk(rd_data, {8'h0, 13'h1ABC, VA1[10:0]});
        // same index, other tag: misses, then fills way b
        wr(`OFF_SAR, {8'h0, VA2}, `RESP_OKAY);
        outs(6'h04);
        wr(`OFF_REFILL, {8'h0, ent(13'h0F0F, 1'h0, {4'h3, 3'h6})}, `RESP_OKAY);
        wr(`OFF_SAR, {8'h0, VA2}, `RESP_OKAY);
        outs(6'h18);
        chk(cache_page_b, 13'h0F0F);
        chk(cache_page_a, 13'h1ABC);
        miss_run(4'h0);
        chk(main_memory_address_bus, 13'h0F0F);
        chk(main_memory_write, 1'h0);
        // write access to a write-protected page
        wr(`OFF_SCR, XON | 32'h00010000, `RESP_OKAY);
        wr(`OFF_SAR, {8'h0, VA1}, `RESP_OKAY);
        outs(6'h22);
        rd(`OFF_STATUS);
        chk(rd_data[2], 1'h1);
        wr(`OFF_SAR, {8'h0, VA2}, `RESP_OKAY);
        outs(6'h18);
        miss_run(4'h3);
        chk(main_memory_address_bus, 13'h0F0F);
        chk(main_memory_write, 1'h1);
        // same entry in both ways is a double hit
        wr(`OFF_SCR, XON, `RESP_OKAY);
        wr(`OFF_SAR, {8'h0, VA3}, `RESP_OKAY);
        for (k = 0; k < 2; k = k + 1) begin
            wr(`OFF_REFILL, {8'h0, ent(13'h0123, 1'h0, {4'h7, 3'h1})}, `RESP_OKAY);
        end
        wr(`OFF_SAR, {8'h0, VA3}, `RESP_OKAY);
        outs(6'h31);
        wr(`OFF_PSW, 32'h0, `RESP_OKAY);
        wr(`OFF_SAR, {8'h0, VA3}, `RESP_OKAY);
        outs(6'h28);
        chk(cache_page_a, VA3[23:11]);
        // unmapped and unaligned places are refused
        wr(8'h1C, 32'h0, `RESP_DECERR);
        wr(8'h02, 32'h0, `RESP_DECERR);
        rd(8'hFC);
        chk(rd_resp, `RESP_DECERR);
        close_out;
    end
endmodule
